// File: cpmc_core.sv
// measurement core: registers, conversion sequencer, averaging
// Operation
// - config bits 5:3 pick shunt conversion time, 140us up to 8.244ms
// - mode bits 2:0: 0/4 off, 1-3 triggered, 5-7 continuous
// - reset mode is continuous shunt and rail
// - shunt reading at 01h is signed two's complement
// - shunt code 7fff is full scale, one code per step
// - all four results present averaged values when averaging
// - rail reading at 02h holds latest rail measurement
// - top bit of rail reading always reads zero
// - power at 03h from current times rail, step 25 current steps
// - current at 04h is shunt times calibration / 2048, signed
// - calibration at 05h, low 15 bits used, bit 15 ignored
// - zero calibration keeps current and power at zero
// - config write aborts and restarts, or stops in modes 0/4; config read has no effect
// - ready only after conversions, averaging, arithmetic all finish
`timescale 1ns/1ps
module cpmc_core #(
    parameter int unsigned CONV_CYC [8] = cpmc_pkg::CT_CYC
) (
    input wire logic CORE_CLK_I,
    input wire logic ARST_N_I,
    input wire logic CE_I,
    input wire cpmc_pkg::cpmc_addr_t REG_ADDR_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire cpmc_pkg::cpmc_word_t REG_WDATA_I,
    input wire logic signed [15:0] SHUNT_ADC_I,
    input wire logic [14:0] RAIL_ADC_I,
    output cpmc_pkg::cpmc_word_t REG_RDATA_O,
    output logic CONV_READY_O
);
    import cpmc_pkg::*;

    cpmc_math_if mif ();

    cpmc_math u_math (
        .clk_i(CORE_CLK_I),
        .arst_n_i(ARST_N_I),
        .ce_i(CE_I),
        .mif(mif)
    );

    // =========================================================
    // register group
    cpmc_word_t cfg_q, cfg_d;
    logic [14:0] scale_q, scale_d;
    cpmc_word_t rdata_q, rdata_d;
    logic cfg_wr;
    logic signed [15:0] shunt_q, shunt_d;
    logic [14:0] rail_q, rail_d;
    logic [15:0] cur_q, cur_d;
    logic [15:0] pwr_q, pwr_d;

    assign cfg_wr = REG_WR_I && (REG_ADDR_I == OFS_CONFIG);

    always_comb begin
        cfg_d = cfg_q;
        scale_d = scale_q;
        rdata_d = rdata_q;
        if (REG_WR_I) begin
            if (REG_ADDR_I == OFS_CONFIG) begin
                cfg_d = REG_WDATA_I;
                cfg_d[CONFIG_RST_BIT] = 1'b0;
            end
            if (REG_ADDR_I == OFS_SCALE_FACTOR) begin
                scale_d = REG_WDATA_I[14:0];
            end
        end
        if (REG_RD_I) begin
            unique case (REG_ADDR_I)
                OFS_CONFIG: rdata_d = cfg_q;
                OFS_SHUNT_READING: rdata_d = shunt_q;
                OFS_BUS_READING: rdata_d = {1'b0, rail_q};
                OFS_POWER_RESULT: rdata_d = pwr_q;
                OFS_CURRENT_RESULT: rdata_d = cur_q;
                OFS_SCALE_FACTOR: rdata_d = {1'b0, scale_q};
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cfg_q <= CONFIG_RST;
            scale_q <= 15'h0000;
            rdata_q <= DATA_RST;
        end else if (CE_I) begin
            cfg_q <= cfg_d;
            scale_q <= scale_d;
            rdata_q <= rdata_d;
        end
    end

    // =========================================================
    // mode decode on the value in force and on the config write data
    logic [2:0] op_sel, wr_sel;
    logic shunt_en, rail_en, cont_en;
    logic wr_measure;
    int unsigned sh_ct_idx, rl_ct_idx, avg_idx;

    assign op_sel = cfg_q[OP_SELECT_LSB +: 3];
    assign wr_sel = REG_WDATA_I[OP_SELECT_LSB +: 3];
    assign shunt_en = op_sel[0];
    assign rail_en = op_sel[1];
    assign cont_en = op_sel[2];
    assign wr_measure = (wr_sel[1:0] != 2'b00);
    assign sh_ct_idx = 32'(cfg_q[SHUNT_CT_LSB +: 3]);
    assign rl_ct_idx = 32'(cfg_q[RAIL_CT_LSB +: 3]);
    assign avg_idx = 32'(cfg_q[AVG_LSB +: 3]);

    // =========================================================
    // sequencer group
    cpmc_state_t state_q, state_d;
    cpmc_cyc_t cnt_q, cnt_d;
    logic [9:0] avg_cnt_q, avg_cnt_d;
    logic signed [25:0] acc_sh_q, acc_sh_d;
    logic [24:0] acc_rl_q, acc_rl_d;
    logic ready_q, ready_d;
    logic start_q, start_d;
    logic [9:0] avg_max;
    cpmc_cyc_t sh_last, rl_last;

    assign avg_max = 10'((11'h001 << AVG_SHIFT[avg_idx]) - 11'h001);
    assign sh_last = cpmc_cyc_t'(CONV_CYC[sh_ct_idx] - 1);
    assign rl_last = cpmc_cyc_t'(CONV_CYC[rl_ct_idx] - 1);

    always_comb begin
        logic sample_end;
        sample_end = 1'b0;
        state_d = state_q;
        cnt_d = cnt_q;
        avg_cnt_d = avg_cnt_q;
        acc_sh_d = acc_sh_q;
        acc_rl_d = acc_rl_q;
        ready_d = ready_q;
        start_d = 1'b0;
        shunt_d = shunt_q;
        rail_d = rail_q;
        cur_d = cur_q;
        pwr_d = pwr_q;
        unique case (state_q)
            ST_IDLE: begin
            end
            ST_SHUNT: begin
                if (cnt_q == sh_last) begin
                    acc_sh_d = acc_sh_q + 26'(SHUNT_ADC_I);
                    cnt_d = '0;
                    if (rail_en) begin
                        state_d = ST_RAIL;
                    end else begin
                        sample_end = 1'b1;
                    end
                end else begin
                    cnt_d = cnt_q + 21'h000001;
                end
            end
            ST_RAIL: begin
                if (cnt_q == rl_last) begin
                    acc_rl_d = acc_rl_q + 25'(RAIL_ADC_I);
                    cnt_d = '0;
                    sample_end = 1'b1;
                end else begin
                    cnt_d = cnt_q + 21'h000001;
                end
            end
            ST_MATH: begin
                if (mif.done) begin
                    cur_d = mif.current;
                    pwr_d = mif.power;
                    ready_d = 1'b1;
                    acc_sh_d = '0;
                    acc_rl_d = '0;
                    avg_cnt_d = '0;
                    if (cont_en) begin
                        state_d = shunt_en ? ST_SHUNT : ST_RAIL;
                    end else begin
                        state_d = ST_IDLE;
                    end
                end
            end
        endcase
        if (sample_end) begin
            if (avg_cnt_q == avg_max) begin
                if (shunt_en) begin
                    shunt_d = 16'(acc_sh_d >>> AVG_SHIFT[avg_idx]);
                end
                if (rail_en) begin
                    rail_d = 15'(acc_rl_d >> AVG_SHIFT[avg_idx]);
                end
                start_d = 1'b1;
                state_d = ST_MATH;
            end else begin
                avg_cnt_d = avg_cnt_q + 10'h001;
                state_d = shunt_en ? ST_SHUNT : ST_RAIL;
            end
        end
        if (cfg_wr) begin
            cnt_d = '0;
            avg_cnt_d = '0;
            acc_sh_d = '0;
            acc_rl_d = '0;
            start_d = 1'b0;
            if (wr_measure) begin
                state_d = wr_sel[0] ? ST_SHUNT : ST_RAIL;
                if (!(state_q == ST_MATH && mif.done)) begin
                    ready_d = 1'b0;
                end
            end else begin
                state_d = ST_IDLE;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_q <= ST_SHUNT;
            cnt_q <= '0;
            avg_cnt_q <= '0;
            acc_sh_q <= '0;
            acc_rl_q <= '0;
            ready_q <= 1'b0;
            start_q <= 1'b0;
            shunt_q <= '0;
            rail_q <= '0;
            cur_q <= DATA_RST;
            pwr_q <= DATA_RST;
        end else if (CE_I) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            avg_cnt_q <= avg_cnt_d;
            acc_sh_q <= acc_sh_d;
            acc_rl_q <= acc_rl_d;
            ready_q <= ready_d;
            start_q <= start_d;
            shunt_q <= shunt_d;
            rail_q <= rail_d;
            cur_q <= cur_d;
            pwr_q <= pwr_d;
        end
    end

    // raw codes passed at one code per step
    assign mif.start = start_q;
    assign mif.shunt = shunt_q;
    assign mif.rail = rail_q;
    assign mif.scale = scale_q;

    assign REG_RDATA_O = rdata_q;
    assign CONV_READY_O = ready_q;

endmodule // cpmc_core

// File: cpmc_core_assertions.sv
// concurrent checks on the ports of the measurement core
`timescale 1ns/1ps
module cpmc_chk #(
    parameter int unsigned CONV_CYC [8] = cpmc_pkg::CT_CYC
) (
    input wire logic CORE_CLK_I,
    input wire logic ARST_N_I,
    input wire logic CE_I,
    input wire cpmc_pkg::cpmc_addr_t REG_ADDR_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire cpmc_pkg::cpmc_word_t REG_WDATA_I,
    input wire logic signed [15:0] SHUNT_ADC_I,
    input wire logic [14:0] RAIL_ADC_I,
    input wire cpmc_pkg::cpmc_word_t REG_RDATA_O,
    input wire logic CONV_READY_O
);
    import cpmc_pkg::*;
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    // ==========================================================
    // shadow of config and cycles since last measuring write
    logic rd_ok, wr_cfg, wr_meas, pd;
    cpmc_word_t cfg_q;
    logic [15:0] cnt_q;
    logic cal0_q, cfgw_q;
    int unsigned exp_c;
    assign rd_ok = CE_I && REG_RD_I;
    assign wr_cfg = CE_I && REG_WR_I && REG_ADDR_I == OFS_CONFIG;
    assign wr_meas = wr_cfg && REG_WDATA_I[1:0] != 2'h0;
    assign pd = cfg_q[1:0] == 2'h0;
    always_comb begin
        exp_c = (((cfg_q[0] ? CONV_CYC[cfg_q[5:3]] : 0) + (cfg_q[1] ? CONV_CYC[cfg_q[8:6]] : 0))
            << AVG_SHIFT[cfg_q[11:9]]) + 3;
    end
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cfg_q <= CONFIG_RST;
            cnt_q <= 16'h0000;
            cal0_q <= 1'b1;
            cfgw_q <= 1'b0;
        end else begin
            if (wr_cfg) begin
                cfg_q <= REG_WDATA_I;
                cfgw_q <= 1'b1;
            end
            if (wr_meas) begin
                cnt_q <= 16'h0000;
            end else if (CE_I && cnt_q != 16'hffff) begin
                cnt_q <= cnt_q + 16'h0001;
            end
            if (CE_I && REG_WR_I && REG_ADDR_I == OFS_SCALE_FACTOR
                && REG_WDATA_I[14:0] != 15'h0) begin
                cal0_q <= 1'b0;
            end
        end
    end
    // ==========================================================
    // assertions
    rail_msb_zero_a: assert property (
        rd_ok && REG_ADDR_I == OFS_BUS_READING |=> !REG_RDATA_O[15]
    ) else $error("rail reading top bit set");
    cal_msb_zero_a: assert property (
        rd_ok && REG_ADDR_I == OFS_SCALE_FACTOR |=> !REG_RDATA_O[15]
    ) else $error("calibration top bit set");
    reset_mode_a: assert property (
        !cfgw_q && rd_ok && REG_ADDR_I == OFS_CONFIG |=> REG_RDATA_O[2:0] == 3'h7
    ) else $error("reset mode not continuous both");
    cal_zero_result_a: assert property (
        cal0_q && rd_ok && (REG_ADDR_I == OFS_CURRENT_RESULT || REG_ADDR_I == OFS_POWER_RESULT)
        |=> REG_RDATA_O == 16'h0000
    ) else $error("result nonzero with zero calibration");
    ready_clear_a: assert property (
        wr_meas ##1 !CONV_READY_O |=> !CONV_READY_O [*3]
    ) else $error("ready rose too soon after config write");
    ready_hold_a: assert property (
        CONV_READY_O && !wr_meas |=> CONV_READY_O
    ) else $error("ready dropped without config write");
    pd_no_rise_a: assert property (
        pd && $past(pd) |-> !$rose(CONV_READY_O)
    ) else $error("ready rose in power-down");
    ready_timing_a: assert property (
        $rose(CONV_READY_O) && !$past(wr_meas) |-> cnt_q >= exp_c[15:0]
    ) else $error("ready before sequence could finish");
    cover property ($rose(CONV_READY_O) && !cfg_q[2]);
    cover property (pd && CONV_READY_O);
    cover property (rd_ok && REG_ADDR_I == OFS_CURRENT_RESULT && !cal0_q);
endmodule // cpmc_chk

// File: cpmc_host.sv
// host model: drives the register strobe port of the core
`timescale 1ns/1ps
module cpmc_host (
    input wire logic clk_i,
    input wire cpmc_pkg::cpmc_word_t rdata_i,
    output cpmc_pkg::cpmc_addr_t addr_o,
    output logic wr_o,
    output logic rd_o,
    output cpmc_pkg::cpmc_word_t wdata_o
);
    import cpmc_pkg::*;
    initial begin
        addr_o = 8'hff;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 16'hffff;
    end
    task automatic wr(input cpmc_addr_t a, input cpmc_word_t d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
    task automatic rd(input cpmc_addr_t a, output cpmc_word_t d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        rd_o = 1'b1;
        @(posedge clk_i);
        #1;
        rd_o = 1'b0;
        addr_o = ~a;
        d = rdata_i;
    endtask
endmodule // cpmc_host

// File: cpmc_math.sv
// current and power arithmetic: two registered stages
`timescale 1ns/1ps
module cpmc_math (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    cpmc_math_if.math mif
);
    import cpmc_pkg::*;

    logic signed [15:0] cur_q, cur_d;
    logic [15:0] pwr_q, pwr_d;
    logic stage_q, stage_d;
    logic done_q, done_d;
    logic signed [31:0] cur_prod;
    logic [16:0] cur_mag;
    logic [31:0] pwr_prod;

    // =========================================================
    // arithmetic
    always_comb begin
        cur_prod = mif.shunt * $signed({1'b0, mif.scale});
        cur_mag = cur_q[15] ? 17'(-{cur_q[15], cur_q}) : {1'b0, cur_q};
        // current times rail, power step 25 current steps
        pwr_prod = 32'(cur_mag) * 32'(mif.rail);
        cur_d = cur_q;
        pwr_d = pwr_q;
        stage_d = 1'b0;
        done_d = 1'b0;
        if (mif.start) begin
            cur_d = 16'(cur_prod >>> CUR_SHIFT);
            stage_d = 1'b1;
        end else if (stage_q) begin
            pwr_d = 16'(pwr_prod / POWER_DIV);
            done_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cur_q <= '0;
            pwr_q <= '0;
            stage_q <= 1'b0;
            done_q <= 1'b0;
        end else if (ce_i) begin
            cur_q <= cur_d;
            pwr_q <= pwr_d;
            stage_q <= stage_d;
            done_q <= done_d;
        end
    end

    assign mif.current = cur_q;
    assign mif.power = pwr_q;
    assign mif.done = done_q;

endmodule // cpmc_math

// File: cpmc_math_if.sv
// carrier between the sequencer and the arithmetic unit
`timescale 1ns/1ps
interface cpmc_math_if;
    logic start;
    logic signed [15:0] shunt;
    logic [14:0] rail;
    logic [14:0] scale;
    logic [15:0] current;
    logic [15:0] power;
    logic done;

    modport seq (output start, output shunt, output rail, output scale,
                 input current, input power, input done);
    modport math (input start, input shunt, input rail, input scale,
                  output current, output power, output done);
endinterface

// File: cpmc_pkg.sv
// shared constants and types of the current and power monitor core
package cpmc_pkg;

    typedef logic [15:0] cpmc_word_t;
    typedef logic [7:0] cpmc_addr_t;
    typedef logic [20:0] cpmc_cyc_t;

    // =========================================================
    // register offsets
    localparam cpmc_addr_t OFS_CONFIG = 8'h00;
    localparam cpmc_addr_t OFS_SHUNT_READING = 8'h01;
    localparam cpmc_addr_t OFS_BUS_READING = 8'h02;
    localparam cpmc_addr_t OFS_POWER_RESULT = 8'h03;
    localparam cpmc_addr_t OFS_CURRENT_RESULT = 8'h04;
    localparam cpmc_addr_t OFS_SCALE_FACTOR = 8'h05;

    // =========================================================
    // reset values
    localparam cpmc_word_t CONFIG_RST = 16'h4127;
    localparam cpmc_word_t DATA_RST = 16'h0000;

    // =========================================================
    // configuration field positions
    localparam int unsigned AVG_LSB = 9;
    localparam int unsigned RAIL_CT_LSB = 6;
    localparam int unsigned SHUNT_CT_LSB = 3;
    localparam int unsigned OP_SELECT_LSB = 0;
    localparam int unsigned CONFIG_RST_BIT = 15;

    // =========================================================
    // conversion times, ns, and derived cycle counts at 4 ns
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned CT_NS [8] = '{140000, 204000, 332000, 588000,
                                          1100000, 2116000, 4156000, 8244000};

    function automatic int unsigned ns_to_cyc(input int unsigned ns);
        return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction

    localparam int unsigned CT_CYC [8] = '{ns_to_cyc(CT_NS[0]), ns_to_cyc(CT_NS[1]),
                                           ns_to_cyc(CT_NS[2]), ns_to_cyc(CT_NS[3]),
                                           ns_to_cyc(CT_NS[4]), ns_to_cyc(CT_NS[5]),
                                           ns_to_cyc(CT_NS[6]), ns_to_cyc(CT_NS[7])};

    // averaging: sample count is 1 << shift
    localparam int unsigned AVG_SHIFT [8] = '{0, 2, 4, 6, 7, 8, 9, 10};

    // =========================================================
    // arithmetic scaling
    localparam int unsigned CUR_SHIFT = 11;
    // power step is 25 current steps, rail step 1.25 mV: divide by 25 / 1.25e-3
    localparam int unsigned POWER_DIV = 20000;

    // =========================================================
    // sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SHUNT = 4'b0010,
        ST_RAIL = 4'b0100,
        ST_MATH = 4'b1000
    } cpmc_state_t;

endpackage

// File: tb.sv
// self-checking testbench of the measurement core
`timescale 1ns/1ps
module tb;
    import cpmc_pkg::*;
    localparam int unsigned CC [8] = '{2, 3, 4, 5, 6, 7, 8, 9};
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic wr, rd, rdy;
    cpmc_addr_t addr;
    cpmc_word_t wdata, rdata, got;
    logic signed [15:0] shunt = 16'h8300;
    logic [14:0] rail = 15'h4e20;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    always #2 clk = ~clk;

    cpmc_host host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .rd_o(rd),
        .wdata_o(wdata));
    cpmc_core #(.CONV_CYC(CC)) dut (.CORE_CLK_I(clk), .ARST_N_I(arst_n), .CE_I(ce),
        .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd), .REG_WDATA_I(wdata),
        .SHUNT_ADC_I(shunt), .RAIL_ADC_I(rail), .REG_RDATA_O(rdata), .CONV_READY_O(rdy));

    task automatic chk(input string what, input cpmc_word_t exp, input cpmc_word_t seen);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rdchk(input string what, input cpmc_addr_t a, input cpmc_word_t exp);
        host.rd(a, got);
        chk(what, exp, got);
    endtask
    task automatic wait_rdy(output int n);
        n = 0;
        while (rdy !== 1'b1 && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    task automatic run_cfg(input cpmc_word_t cfg, input int n_exp);
        int n;
        host.wr(OFS_CONFIG, cfg);
        chk("ready cleared", 16'h0, {15'h0, rdy});
        wait_rdy(n);
        chk("cycles to ready", n_exp[15:0], n[15:0]);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        int n;
        wait_rdy(n);
        chk("ready after reset", 16'h1, {15'h0, rdy});
        rdchk("config", OFS_CONFIG, CONFIG_RST);
        rdchk("current", OFS_CURRENT_RESULT, 16'h0);
        rdchk("power", OFS_POWER_RESULT, 16'h0);
        rdchk("shunt", OFS_SHUNT_READING, 16'h8300);
        rdchk("rail", OFS_BUS_READING, 16'h4e20);
        $display("test reset done");
    endtask
    task automatic t_cal();
        host.wr(OFS_SCALE_FACTOR, 16'hffff);
        rdchk("scale", OFS_SCALE_FACTOR, 16'h7fff);
        host.wr(OFS_SHUNT_READING, 16'h1234);
        rdchk("shunt read-only", OFS_SHUNT_READING, 16'h8300);
        rdchk("unmapped", 8'h06, 16'h0);
        $display("test cal done");
    endtask
    task automatic t_math();
        host.wr(OFS_SCALE_FACTOR, 16'h0800);
        run_cfg(16'h0003, 7);
        rdchk("shunt", OFS_SHUNT_READING, 16'h8300);
        rdchk("current", OFS_CURRENT_RESULT, 16'h8300);
        rdchk("power", OFS_POWER_RESULT, 16'h7d00);
        shunt = 16'h0123;
        repeat (30) @(posedge clk);
        rdchk("held", OFS_SHUNT_READING, 16'h8300);
        $display("test math done");
    endtask
    task automatic t_times();
        shunt = 16'h0100;
        for (int k = 0; k < 8; k++) begin
            run_cfg(cpmc_word_t'(k * 8 + 1), CC[k] + 3);
        end
        run_cfg(16'h0201, 4 * CC[0] + 3);
        rdchk("averaged shunt", OFS_SHUNT_READING, 16'h0100);
        $display("test times done");
    endtask
    task automatic t_abort();
        int n;
        host.wr(OFS_CONFIG, 16'h0003);
        rdchk("config", OFS_CONFIG, 16'h0003);
        wait_rdy(n);
        chk("read keeps run", 16'h5, n[15:0]);
        host.wr(OFS_CONFIG, 16'h0003);
        run_cfg(16'h0003, 7);
        $display("test abort done");
    endtask
    task automatic t_modes();
        cpmc_word_t os, orl;
        for (int m = 0; m < 8; m++) begin
            host.wr(OFS_CONFIG, 16'h0000);
            host.rd(OFS_SHUNT_READING, os);
            host.rd(OFS_BUS_READING, orl);
            shunt = 16'(16 * (m + 1));
            rail = 15'(32 * (m + 1));
            host.wr(OFS_CONFIG, cpmc_word_t'(m));
            repeat (40) @(posedge clk);
            rdchk("mode shunt", OFS_SHUNT_READING, (m % 2 == 1) ? 16'(16 * (m + 1)) : os);
            rdchk("mode rail", OFS_BUS_READING, (m % 4 >= 2) ? 16'(32 * (m + 1)) : orl);
        end
        $display("test modes done");
    endtask
    task automatic t_pd();
        host.wr(OFS_CONFIG, 16'h0004);
        chk("ready kept", 16'h1, {15'h0, rdy});
        $display("test power-down done");
    endtask
    task automatic t_freeze();
        int n;
        host.wr(OFS_CONFIG, 16'h0003);
        ce = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        chk("ready frozen", 16'h0, {15'h0, rdy});
        ce = 1'b1;
        wait_rdy(n);
        chk("cycles after freeze", 16'h7, n[15:0]);
        $display("test freeze done");
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            complete_run();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        #1;
        arst_n = 1'b1;
        t_reset();
        t_cal();
        t_math();
        t_times();
        t_abort();
        t_modes();
        t_pd();
        t_freeze();
        complete_run();
    end
endmodule // tb

bind cpmc_core cpmc_chk #(.CONV_CYC(CONV_CYC)) u_chk (.CORE_CLK_I(CORE_CLK_I),
    .ARST_N_I(ARST_N_I), .CE_I(CE_I), .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I),
    .REG_RD_I(REG_RD_I), .REG_WDATA_I(REG_WDATA_I), .SHUNT_ADC_I(SHUNT_ADC_I),
    .RAIL_ADC_I(RAIL_ADC_I), .REG_RDATA_O(REG_RDATA_O), .CONV_READY_O(CONV_READY_O));
